// ---- rtl/rbqf_bank.sv ----
// Purpose: Twelve time-shared biquad sections allocated to up to eight record channels.
// Assumes: Coefficients and allocation are loaded through plain write strobes, frames of
//          eight signed samples arrive on a valid/ready stream at the output sample rate.
// Notes:   One section is evaluated per clock, so a filtered frame takes twelve cycles plus a push; a bypass frame only the push.
`timescale 1ns/1ns
`default_nettype none
module rbqf_bank
  import rbqf_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire rbqf_coef_wr_type coef_wr,
  input  wire logic             alloc_wr_en,
  input  wire logic [1:0]       alloc_wr_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire rbqf_frame_type   in_frame,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output rbqf_frame_type        out_frame,
  output logic [1:0]            active_alloc,
  output logic                  busy
);
  typedef struct packed {
    rbqf_phase_type                        phase;
    logic [1:0]                            channel_filter_config;
    logic [1:0]                            alloc_live;
    logic [3:0]                            sec;
    rbqf_frame_type                        work;
    logic [SEC_COUNT-1:0][COEF_W*5-1:0]    coefs;
    logic [SEC_COUNT-1:0][SAMPLE_W*4-1:0]  hist;
  } rbqf_core_type;

  rbqf_core_type      state_reg;
  rbqf_core_type      state_next;
  rbqf_map_type       map;
  rbqf_coef_set_type  cf;
  rbqf_hist_type      h;
  logic [SAMPLE_W-1:0] x;
  logic [SAMPLE_W-1:0] y;
  logic [ACC_W-1:0]   acc;
  logic               fifo_push;
  logic               fifo_ready;

  // Channel served by a section under a given allocation.
  function automatic rbqf_map_type chan_of(input logic [1:0] alloc, input logic [3:0] sec);
    rbqf_map_type m;
    m = '0;
    unique case (alloc)
      ALLOC_BYPASS:
      begin
        m.used = 1'b0;
      end
      ALLOC_ONE:
      begin
        m.used = (sec < SEC_SPARE_LO) || (sec > SEC_SPARE_HI);
        m.ch   = sec[3] ? 3'(sec - SEC_SPARE_LO) : 3'(sec);
      end
      ALLOC_TWO:
      begin
        m.used = 1'b1;
        m.ch   = sec[3] ? {2'b10, sec[0]} : {1'b0, sec[1:0]};
      end
      ALLOC_THREE:
      begin
        m.used = 1'b1;
        m.ch   = {1'b0, sec[1:0]};
      end
    endcase
    return m;
  endfunction

  assign in_ready     = (state_reg.phase == PH_IDLE);
  assign busy         = (state_reg.phase != PH_IDLE);
  assign active_alloc = state_reg.channel_filter_config;
  assign fifo_push    = (state_reg.phase == PH_PUSH);

  // Coefficients are signed; each product is sign-extended to the accumulator width.
  always_comb
  begin
    map = chan_of(state_reg.alloc_live, state_reg.sec);
    cf  = rbqf_coef_set_type'(state_reg.coefs[state_reg.sec]);
    h   = rbqf_hist_type'(state_reg.hist[state_reg.sec]);
    x   = state_reg.work[map.ch];
    acc = ACC_W'($signed(cf.numerator_coef_zero)) * ACC_W'($signed(x))
        + ((ACC_W'($signed(cf.numerator_coef_one)) * ACC_W'($signed(h.x1))) <<< 1)
        + ACC_W'($signed(cf.numerator_coef_two)) * ACC_W'($signed(h.x2))
        + ((ACC_W'($signed(cf.denominator_coef_one)) * ACC_W'($signed(h.y1))) <<< 1)
        + ACC_W'($signed(cf.denominator_coef_two)) * ACC_W'($signed(h.y2));
    // Saturate rather than wrap, so an unstable design clips instead of folding over.
    if (acc[ACC_W-1:FRAC_SHIFT+SAMPLE_W-1] != {(ACC_W-FRAC_SHIFT-SAMPLE_W+1){acc[ACC_W-1]}})
    begin
      y = acc[ACC_W-1] ? SAT_NEG : SAT_POS;
    end
    else
    begin
      y = acc[FRAC_SHIFT+SAMPLE_W-1:FRAC_SHIFT];
    end
  end

  always_comb
  begin
    state_next = state_reg;
    if (alloc_wr_en)
    begin
      state_next.channel_filter_config = alloc_wr_data;
    end
    // Writes land at once; loading while frames run mixes old and new sets mid-stream.
    if (coef_wr.wr_en && (coef_wr.section <= SEC_LAST))
    begin
      unique case (coef_wr.sel)
        SEL_N0: state_next.coefs[coef_wr.section][COEF_W*5-1:COEF_W*4] = coef_wr.data;
        SEL_N1: state_next.coefs[coef_wr.section][COEF_W*4-1:COEF_W*3] = coef_wr.data;
        SEL_N2: state_next.coefs[coef_wr.section][COEF_W*3-1:COEF_W*2] = coef_wr.data;
        SEL_D1: state_next.coefs[coef_wr.section][COEF_W*2-1:COEF_W] = coef_wr.data;
        SEL_D2: state_next.coefs[coef_wr.section][COEF_W-1:0] = coef_wr.data;
        default: state_next.coefs = state_reg.coefs;
      endcase
    end
    unique case (state_reg.phase)
      PH_IDLE:
      begin
        if (in_valid)
        begin
          state_next.work       = in_frame;
          state_next.alloc_live = state_reg.channel_filter_config;
          state_next.sec        = SEC_FIRST;
          if (state_reg.channel_filter_config == ALLOC_BYPASS)
          begin
            state_next.phase = PH_PUSH;
          end
          else
          begin
            state_next.phase = PH_RUN;
          end
        end
      end
      PH_RUN:
      begin
        if (map.used)
        begin
          state_next.work[map.ch]       = y;
          state_next.hist[state_reg.sec] = {x, h.x1, y, h.y1};
        end
        if (state_reg.sec == SEC_LAST)
        begin
          state_next.phase = PH_PUSH;
        end
        else
        begin
          state_next.sec = state_reg.sec + SEC_STEP;
        end
      end
      PH_PUSH:
      begin
        if (fifo_ready)
        begin
          state_next.phase = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg.phase                 <= PH_IDLE;
      state_reg.channel_filter_config <= ALLOC_RESET;
      state_reg.alloc_live            <= ALLOC_RESET;
      state_reg.sec                   <= SEC_FIRST;
      state_reg.work                  <= '0;
      state_reg.coefs                 <= {SEC_COUNT{COEF_SET_RESET}};
      state_reg.hist                  <= {SEC_COUNT{HIST_RESET}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  rbqf_fifo #(
    .WIDTH ($bits(rbqf_frame_type)),
    .DEPTH (FIFO_DEPTH)
  ) rbqf_fifo_i (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (state_reg.work),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_frame)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_frame_start;
    state_reg.phase == PH_RUN && state_reg.sec == SEC_FIRST;
  endsequence

  sequence s_frame_end;
    state_reg.phase == PH_RUN && state_reg.sec == SEC_LAST ##1 state_reg.phase == PH_PUSH;
  endsequence

  a_run_twelve_steps: assert property (s_frame_start |-> ##11 s_frame_end)
    else $error("Section sweep did not take twelve cycles.");

  a_cascade_ascending: assert property (
    state_reg.phase == PH_RUN && state_reg.sec != SEC_LAST
    |=> state_reg.sec == $past(state_reg.sec) + SEC_STEP)
    else $error("Sections were not visited in ascending order.");

  a_history_shift: assert property (
    state_reg.phase == PH_RUN && map.used
    |=> state_reg.hist[$past(state_reg.sec)] == {$past(x), $past(h.x1), $past(y), $past(h.y1)})
    else $error("Section history did not shift.");

  a_default_unity: assert property (
    state_reg.phase == PH_RUN && map.used && cf == COEF_SET_RESET && h == HIST_RESET
    |=> state_reg.work[$past(map.ch)] == $past(x)
        || state_reg.work[$past(map.ch)] == $past(x) - 32'h00000001)
    else $error("Default coefficients changed the signal.");

  a_coef_stored: assert property (
    coef_wr.wr_en && coef_wr.section <= SEC_LAST && coef_wr.sel == SEL_N0
    |=> state_reg.coefs[$past(coef_wr.section)][COEF_W*5-1:COEF_W*4] == $past(coef_wr.data))
    else $error("Coefficient write was not stored.");

  a_alloc_write: assert property (
    alloc_wr_en |=> active_alloc == $past(alloc_wr_data))
    else $error("Allocation write was not taken.");

  a_bypass_direct: assert property (
    in_valid && in_ready && state_reg.channel_filter_config == ALLOC_BYPASS
    |=> state_reg.phase == PH_PUSH && state_reg.work == $past(in_frame))
    else $error("Bypass frame was altered or delayed.");

  a_spare_idle: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_ONE
    && state_reg.sec >= SEC_SPARE_LO && state_reg.sec <= SEC_SPARE_HI
    |=> $stable(state_reg.work))
    else $error("An unused section touched the frame.");

  a_two_map_high: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_TWO && state_reg.sec[3]
    |-> map.used && map.ch == (state_reg.sec[0] ? 3'h5 : 3'h4))
    else $error("Upper sections mapped to the wrong channel.");

  a_three_map: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_THREE
    |-> map.used && map.ch == 3'(state_reg.sec % 4'h4))
    else $error("Three-per-channel map is wrong.");

  a_push_waits: assert property (
    state_reg.phase == PH_PUSH && !fifo_ready |=> state_reg.phase == PH_PUSH && $stable(state_reg.work))
    else $error("Frame dropped while the FIFO was full.");

  sequence s_frame_taken;
    in_valid && in_ready;
  endsequence

  // The allocation is frozen per frame so that a mid-frame write cannot split a channel chain.
  a_frame_latch: assert property (
    s_frame_taken |=> state_reg.alloc_live == $past(state_reg.channel_filter_config)
                      && state_reg.work == $past(in_frame))
    else $error("Frame or allocation was not latched at take.");

  a_run_from_first: assert property (
    in_valid && in_ready && state_reg.channel_filter_config != ALLOC_BYPASS
    |=> state_reg.phase == PH_RUN && state_reg.sec == SEC_FIRST)
    else $error("Section sweep did not start at the first section.");

  a_one_map_low: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_ONE
    && state_reg.sec < SEC_SPARE_LO
    |-> map.used && map.ch == state_reg.sec[2:0])
    else $error("Lower sections mapped to the wrong channel.");

  a_one_map_high: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_ONE
    && state_reg.sec > SEC_SPARE_HI
    |-> map.used && map.ch == {1'b1, state_reg.sec[1:0]})
    else $error("Upper single sections mapped to the wrong channel.");

  a_two_map_low: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_TWO && !state_reg.sec[3]
    |-> map.used && map.ch == 3'(state_reg.sec % 4'h4))
    else $error("Lower paired sections mapped to the wrong channel.");

  a_spare_history: assert property (
    state_reg.phase == PH_RUN && state_reg.alloc_live == ALLOC_ONE
    && state_reg.sec >= SEC_SPARE_LO && state_reg.sec <= SEC_SPARE_HI
    |=> $stable(state_reg.hist))
    else $error("An unused section changed its history.");

  a_bypass_no_run: assert property (
    state_reg.phase == PH_RUN |-> state_reg.alloc_live != ALLOC_BYPASS)
    else $error("A bypass frame entered the section sweep.");
endmodule
`default_nettype wire

// ---- rtl/rbqf_pkg.sv ----
// Purpose: Shared constants and types for the record biquad filter bank.
// Assumes: One core clock at fourteen or more times the output sample rate, samples and coefficients 32 bits signed.
// Notes:   Accumulator is wide enough for five 64-bit products, the n1 and d1 products doubled.
package rbqf_pkg;
  localparam int SEC_COUNT  = 12;
  localparam int CHAN_COUNT = 8;
  localparam int SAMPLE_W   = 32;
  localparam int COEF_W     = 32;
  localparam int ACC_W      = 68;
  localparam int FRAC_SHIFT = 31;
  localparam int FIFO_DEPTH = 16;

  localparam logic [1:0] ALLOC_BYPASS = 2'h0;
  localparam logic [1:0] ALLOC_ONE    = 2'h1;
  localparam logic [1:0] ALLOC_TWO    = 2'h2;
  localparam logic [1:0] ALLOC_THREE  = 2'h3;
  localparam logic [1:0] ALLOC_RESET  = 2'h2;

  localparam logic [3:0] SEC_FIRST       = 4'h0;
  localparam logic [3:0] SEC_LAST        = 4'hB;
  localparam logic [3:0] SEC_SPARE_LO    = 4'h4;
  localparam logic [3:0] SEC_SPARE_HI    = 4'h7;
  localparam logic [3:0] SEC_STEP        = 4'h1;
  localparam logic [31:0] N0_RESET       = 32'h7FFFFFFF;
  localparam logic [31:0] COEF_ZERO      = 32'h00000000;
  localparam logic [31:0] SAT_POS        = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG        = 32'h80000000;

  typedef enum logic [2:0] {SEL_N0, SEL_N1, SEL_N2, SEL_D1, SEL_D2} rbqf_coef_sel_type;
  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_PUSH} rbqf_phase_type;

  typedef struct packed {
    logic [COEF_W-1:0] numerator_coef_zero;
    logic [COEF_W-1:0] numerator_coef_one;
    logic [COEF_W-1:0] numerator_coef_two;
    logic [COEF_W-1:0] denominator_coef_one;
    logic [COEF_W-1:0] denominator_coef_two;
  } rbqf_coef_set_type;

  typedef struct packed {
    logic [SAMPLE_W-1:0] x1;
    logic [SAMPLE_W-1:0] x2;
    logic [SAMPLE_W-1:0] y1;
    logic [SAMPLE_W-1:0] y2;
  } rbqf_hist_type;

  typedef struct packed {
    logic              wr_en;
    logic [3:0]        section;
    rbqf_coef_sel_type sel;
    logic [COEF_W-1:0] data;
  } rbqf_coef_wr_type;

  typedef struct packed {
    logic       used;
    logic [2:0] ch;
  } rbqf_map_type;

  typedef logic [CHAN_COUNT-1:0][SAMPLE_W-1:0] rbqf_frame_type;

  localparam rbqf_coef_set_type COEF_SET_RESET = {N0_RESET, {4{COEF_ZERO}}};
  localparam rbqf_hist_type     HIST_RESET     = {4{COEF_ZERO}};
endpackage

// ---- rtl/rbqf_fifo.sv ----
// Purpose: Frame FIFO between the filter engine and the downstream channel logic.
// Assumes: Valid/ready on both sides, a word moves when both are high.
// Notes:   Pointers carry one extra bit so that full and empty are exact.
`timescale 1ns/1ns
`default_nettype none
module rbqf_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } rbqf_fifo_state_type;

  rbqf_fifo_state_type state_reg;
  rbqf_fifo_state_type state_next;

  assign in_ready  = !((state_reg.wr_ptr[AW] != state_reg.rd_ptr[AW]) &&
                       (state_reg.wr_ptr[AW-1:0] == state_reg.rd_ptr[AW-1:0]));
  assign out_valid = (state_reg.wr_ptr != state_reg.rd_ptr);
  assign out_data  = state_reg.mem[state_reg.rd_ptr[AW-1:0]];

  always_comb
  begin
    state_next = state_reg;
    if (in_valid && in_ready)
    begin
      state_next.mem[state_reg.wr_ptr[AW-1:0]] = in_data;
      state_next.wr_ptr = state_reg.wr_ptr + (AW+1)'(1);
    end
    if (out_valid && out_ready)
    begin
      state_next.rd_ptr = state_reg.rd_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

// ---- bench/rbqf_sink.sv ----
// Purpose: Downstream channel logic that accepts filtered frames from the bank.
// Assumes: Standard valid/ready, a frame moves when both are high at a rising edge.
// Notes:   Stall holds ready low to let the FIFO fill; slow accepts every other cycle.
`timescale 1ns/1ns
`default_nettype none
module rbqf_sink
  import rbqf_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rstn,
  input  wire logic           stall,
  input  wire logic           slow,
  input  wire logic           out_valid,
  output logic                out_ready,
  input  wire rbqf_frame_type out_frame
);
  logic           tick_reg;
  rbqf_frame_type got[$];

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      tick_reg <= 1'b0;
    else
      tick_reg <= ~tick_reg;
  end

  assign out_ready = !stall && (!slow || tick_reg);

  always @(posedge core_clk)
  begin
    if (rstn && out_valid && out_ready)
      got.push_back(out_frame);
  end
endmodule
`default_nettype wire

// ---- bench/rbqf_bank_tb.sv ----
// Purpose: Self-checking bench for the biquad bank and its output FIFO.
// Assumes: Inputs change 1 ns after the rising edge; expected values come from the arithmetic.
// Notes:   The coefficient scenario runs first, while every section history is still zero.
`timescale 1ns/1ns
`default_nettype none
module rbqf_bank_tb;
  import rbqf_pkg::*;
  logic             core_clk;
  logic             rstn;
  rbqf_coef_wr_type coef_wr;
  logic             alloc_wr_en;
  logic [1:0]       alloc_wr_data;
  logic             in_valid;
  logic             in_ready;
  rbqf_frame_type   in_frame;
  logic             out_valid;
  logic             out_ready;
  rbqf_frame_type   out_frame;
  logic [1:0]       active_alloc;
  logic             busy;
  logic             stall;
  logic             slow;
  int               miscompares;
  int               comparisons;
  rbqf_frame_type   f;
  rbqf_frame_type   e;

  rbqf_bank rbqf_bank_i (.core_clk(core_clk), .rstn(rstn), .coef_wr(coef_wr),
    .alloc_wr_en(alloc_wr_en), .alloc_wr_data(alloc_wr_data), .in_valid(in_valid),
    .in_ready(in_ready), .in_frame(in_frame), .out_valid(out_valid), .out_ready(out_ready),
    .out_frame(out_frame), .active_alloc(active_alloc), .busy(busy));
  rbqf_sink rbqf_sink_i (.core_clk(core_clk), .rstn(rstn), .stall(stall), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] dfl(input logic [31:0] x, input int n);
    for (int i = 0; i < n; i++)
      if ($signed(x) > 0)
        x = x - 32'h1;
    return x;
  endfunction

  task automatic wc(input logic [3:0] s, input rbqf_coef_sel_type c, input logic [31:0] d);
    @(posedge core_clk);
    #1 coef_wr = '{1'b1, s, c, d};
    @(posedge core_clk);
    #1 coef_wr.wr_en = 1'b0;
  endtask

  task automatic restore(input logic [3:0] s);
    wc(s, SEL_N0, N0_RESET);
    wc(s, SEL_N1, COEF_ZERO);
    wc(s, SEL_N2, COEF_ZERO);
    wc(s, SEL_D1, COEF_ZERO);
    wc(s, SEL_D2, COEF_ZERO);
  endtask

  task automatic set_alloc(input logic [1:0] a);
    @(posedge core_clk);
    #1 alloc_wr_en = 1'b1;
    alloc_wr_data = a;
    @(posedge core_clk);
    #1 alloc_wr_en = 1'b0;
    check(32'(active_alloc), 32'(a));
  endtask

  task automatic send(input rbqf_frame_type x);
    int n;
    n = 0;
    while (in_ready !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 400)
      check(32'h0, 32'h1);
    in_valid = 1'b1;
    in_frame = x;
    @(posedge core_clk);
    #1 in_valid = 1'b0;
  endtask

  task automatic expect_frame(input rbqf_frame_type x);
    int n;
    rbqf_frame_type g;
    n = 0;
    while (rbqf_sink_i.got.size() == 0 && n < 400)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (rbqf_sink_i.got.size() == 0)
      check(32'h0, 32'h1);
    else
    begin
      g = rbqf_sink_i.got.pop_front();
      for (int k = 0; k < CHAN_COUNT; k++)
        check(g[k], x[k]);
    end
  endtask

  task automatic t_reset();
    check(32'(active_alloc), 32'(ALLOC_RESET));
    check(32'({in_ready, busy, out_valid}), 32'h4);
  endtask

  // Section 0 exercises all three numerator taps, 1 and 2 the feedback, with signed values.
  task automatic t_coef();
    logic [31:0] ex [3][3] = '{'{32'h1F4, 32'h1F4, 32'h1F4}, '{32'h1F4, 32'hFA, 32'h0},
                               '{32'hFFFFFC18, 32'h7D, 32'hFFFFFF06}};
    wc(4'h0, SEL_N0, 32'h40000000);
    wc(4'h0, SEL_N1, 32'h20000000);
    wc(4'h0, SEL_N2, 32'h80000000);
    wc(4'h1, SEL_N0, 32'h40000000);
    wc(4'h1, SEL_D1, 32'h20000000);
    wc(4'h2, SEL_N0, 32'h40000000);
    wc(4'h2, SEL_D2, 32'hC0000000);
    wc(SEC_SPARE_LO, SEL_N0, COEF_ZERO);
    set_alloc(ALLOC_ONE);
    for (int i = 0; i < 3; i++)
    begin
      for (int k = 0; k < CHAN_COUNT; k++)
      begin
        f[k] = (i == 0) ? 32'h3E8 : 32'h0;
        e[k] = (k < 3) ? ex[i][k] : dfl(f[k], 1);
      end
      send(f);
      expect_frame(e);
    end
    for (int s = 0; s < 5; s++)
      restore(4'(s));
  endtask

  task automatic t_two();
    wc(4'h9, SEL_N0, 32'h40000000);
    set_alloc(ALLOC_TWO);
    for (int k = 0; k < CHAN_COUNT; k++)
    begin
      f[k] = (k % 2 == 0) ? 32'(100 * (k + 1)) : -32'(100 * (k + 1));
      e[k] = (k < 6) ? dfl(f[k], 2) : f[k];
    end
    e[5] = 32'hFFFFFED4;
    send(f);
    expect_frame(e);
    restore(4'h9);
  endtask

  // A negative full-scale input only lands on 0x40000000 when the halving section runs first.
  task automatic t_three();
    wc(SEC_FIRST, SEL_N0, 32'h40000000);
    wc(4'h8, SEL_N0, 32'h80000000);
    set_alloc(ALLOC_THREE);
    for (int k = 0; k < CHAN_COUNT; k++)
    begin
      f[k] = 32'(1000 + k);
      e[k] = (k < 4) ? dfl(f[k], 3) : f[k];
    end
    f[0] = SAT_NEG;
    e[0] = 32'h40000000;
    send(f);
    expect_frame(e);
    restore(SEC_FIRST);
    restore(4'h8);
  endtask

  task automatic t_bypass_fill();
    set_alloc(ALLOC_BYPASS);
    stall = 1'b1;
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      for (int k = 0; k < CHAN_COUNT; k++)
        f[k] = 32'((k + 1) * 1000 + i);
      send(f);
    end
    repeat (3) @(posedge core_clk);
    #1 check(32'({in_ready, busy, out_valid}), 32'h3);
    stall = 1'b0;
    slow = 1'b1;
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      for (int k = 0; k < CHAN_COUNT; k++)
        e[k] = 32'((k + 1) * 1000 + i);
      expect_frame(e);
    end
    repeat (3) @(posedge core_clk);
    #1 check(32'({in_ready, busy, out_valid}), 32'h4);
  endtask

  // A mid-run reset must drop programmed coefficients and the allocation back to defaults.
  task automatic t_reset_again();
    wc(SEC_FIRST, SEL_N0, 32'h40000000);
    set_alloc(ALLOC_ONE);
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    t_reset();
    for (int k = 0; k < CHAN_COUNT; k++)
    begin
      f[k] = 32'(2000 + k);
      e[k] = (k < 6) ? dfl(f[k], 2) : f[k];
    end
    send(f);
    expect_frame(e);
  endtask

  initial
  begin
    #3000000;
    miscompares++;
    summarize();
  end

  initial
  begin
    miscompares = 0;
    comparisons = 0;
    rstn = 1'b0;
    coef_wr = '{1'b0, 4'h0, SEL_N0, 32'h0};
    alloc_wr_en = 1'b0;
    alloc_wr_data = 2'h0;
    in_valid = 1'b0;
    in_frame = '0;
    stall = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_coef();
    t_two();
    t_three();
    t_bypass_fill();
    t_reset_again();
    summarize();
  end
endmodule
`default_nettype wire
